// ### common/fpcs_pkg.sv
// Shared constants and types of the flash command sequencer host.
package fpcs_pkg;
	localparam int ADDR_W = 24;
	localparam int DATA_W = 16;
	localparam int CNT_W = 8;
	// Command codes written on the low data byte.
	localparam logic [7:0] CMD_BUF_PROG = 8'hE8;
	localparam logic [7:0] CMD_CONFIRM = 8'hD0;
	localparam logic [7:0] CMD_WORD_PROG = 8'h40;
	localparam logic [7:0] CMD_SUSPEND = 8'hB0;
	localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
	localparam logic [7:0] CMD_ERASE = 8'h20;
	localparam logic [7:0] CMD_LOCK_SETUP = 8'h60;
	localparam logic [7:0] CMD_LOCK_CONFIRM = 8'h01;
	localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
	localparam int BUF_AVAIL_BIT = 7;
	localparam logic [CNT_W-1:0] CNT_MAX_BYTE = 8'h1F;
	localparam logic [CNT_W-1:0] CNT_MAX_WORD = 8'h0F;
	localparam int ALIGN_BITS = 5;
	// Bus cycle timing; cycle counts round up to whole clocks.
	localparam int CLK_PERIOD_NS = 8;
	localparam int T_SETUP_NS = 20;
	localparam int T_STROBE_NS = 70;
	localparam int T_HOLD_NS = 20;
	localparam logic [7:0] SETUP_CYC = 8'((T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] STROBE_CYC = 8'((T_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] HOLD_CYC = 8'((T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	typedef enum logic [3:0] {
		OP_PROGRAM, OP_BUF_PROGRAM, OP_ERASE, OP_LOCK, OP_SUSPEND,
		OP_RESUME, OP_CLEAR, OP_READ_ARRAY, OP_READ
	} fpcs_op_t;
	typedef struct packed {
		logic engine_ready_flag;
		logic suspended_flag;
		logic erase_error_flag;
		logic program_error_flag;
		logic voltage_error_flag;
		logic rsv2;
		logic protect_detect_flag;
		logic rsv0;
	} fpcs_stat_t;
	typedef struct packed {
		fpcs_op_t op;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
		logic [CNT_W-1:0] count;
	} fpcs_req_t;
	typedef struct packed {
		logic wr;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} fpcs_cyc_t;
endpackage

// ### hdl/fpcs_bus_cycle.sv
// One asynchronous flash read or write cycle on the device pins.
`timescale 1ns/1ps
module fpcs_bus_cycle (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// Cycle request
	input wire logic start,
	input wire fpcs_pkg::fpcs_cyc_t cyc,
	output logic idle,
	output logic done,
	output logic [fpcs_pkg::DATA_W-1:0] rdata,
	// Device pins
	output logic [fpcs_pkg::ADDR_W-1:0] flash_addr,
	output logic [fpcs_pkg::DATA_W-1:0] flash_dq_o,
	output logic flash_dq_oe,
	input wire logic [fpcs_pkg::DATA_W-1:0] flash_dq_i,
	output logic flash_ce_n,
	output logic flash_oe_n,
	output logic flash_we_n
);
	typedef enum logic [1:0] {B_IDLE, B_SETUP, B_STROBE, B_HOLD} fpcs_bst_t;
	fpcs_bst_t st_r;
	logic [7:0] cnt_r;
	fpcs_pkg::fpcs_cyc_t cyc_r;
	logic [fpcs_pkg::DATA_W-1:0] dq_s1_r;
	logic [fpcs_pkg::DATA_W-1:0] dq_s2_r;

	assign idle = (st_r == B_IDLE);
	assign flash_addr = cyc_r.addr;
	assign flash_dq_o = cyc_r.wdata;

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			dq_s1_r <= '0;
			dq_s2_r <= '0;
		end
		else
		begin
			dq_s1_r <= flash_dq_i;
			dq_s2_r <= dq_s1_r;
		end
	end

	// Each read drops output enable afresh, so status is refreshed on every poll.
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			st_r <= B_IDLE;
			cnt_r <= 8'h00;
			cyc_r <= '0;
			flash_ce_n <= 1'b1;
			flash_oe_n <= 1'b1;
			flash_we_n <= 1'b1;
			flash_dq_oe <= 1'b0;
			done <= 1'b0;
			rdata <= '0;
		end
		else
		begin
			done <= 1'b0;
			case (st_r)
				B_IDLE:
					if (start)
					begin
						cyc_r <= cyc;
						flash_ce_n <= 1'b0;
						flash_dq_oe <= cyc.wr;
						cnt_r <= fpcs_pkg::SETUP_CYC - 8'h01;
						st_r <= B_SETUP;
					end
				B_SETUP:
					if (cnt_r == 8'h00)
					begin
						flash_we_n <= !cyc_r.wr;
						flash_oe_n <= cyc_r.wr;
						cnt_r <= fpcs_pkg::STROBE_CYC - 8'h01;
						st_r <= B_STROBE;
					end
					else
						cnt_r <= cnt_r - 8'h01;
				B_STROBE:
					if (cnt_r == 8'h00)
					begin
						rdata <= dq_s2_r;
						flash_we_n <= 1'b1;
						flash_oe_n <= 1'b1;
						cnt_r <= fpcs_pkg::HOLD_CYC - 8'h01;
						st_r <= B_HOLD;
					end
					else
						cnt_r <= cnt_r - 8'h01;
				B_HOLD:
					if (cnt_r == 8'h00)
					begin
						flash_ce_n <= 1'b1;
						flash_dq_oe <= 1'b0;
						done <= 1'b1;
						st_r <= B_IDLE;
					end
					else
						cnt_r <= cnt_r - 8'h01;
				default:
					st_r <= B_IDLE;
			endcase
		end
	end
endmodule

// ### hdl/fpcs_host_ctrl.sv
// Host sequencer that issues flash program, erase, lock and suspend commands.
`timescale 1ns/1ps
module fpcs_host_ctrl #(
	parameter logic [7:0] BUF_MAX_CNT = fpcs_pkg::CNT_MAX_WORD
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// Order port
	input wire logic req_valid,
	output logic req_ready,
	input wire fpcs_pkg::fpcs_req_t req,
	// Buffer data stream
	input wire logic buf_valid,
	output logic buf_ready,
	input wire logic [fpcs_pkg::ADDR_W-1:0] buf_addr,
	input wire logic [fpcs_pkg::DATA_W-1:0] buf_data,
	// Results
	output logic done,
	output logic refused,
	output logic buf_unaligned,
	output fpcs_pkg::fpcs_stat_t status,
	output logic [fpcs_pkg::DATA_W-1:0] rdata,
	// Device pins
	output logic [fpcs_pkg::ADDR_W-1:0] flash_addr,
	output logic [fpcs_pkg::DATA_W-1:0] flash_dq_o,
	output logic flash_dq_oe,
	input wire logic [fpcs_pkg::DATA_W-1:0] flash_dq_i,
	output logic flash_ce_n,
	output logic flash_oe_n,
	output logic flash_we_n
);
	typedef enum logic [3:0] {
		S_IDLE, S_CMD, S_XSR, S_CNT, S_DATA, S_CONF, S_POLL, S_CLR, S_RD
	} fpcs_st_t;

	if (BUF_MAX_CNT > fpcs_pkg::CNT_MAX_BYTE)
	begin : g_bad_cnt
		$error("BUF_MAX_CNT exceeds the byte mode limit");
	end

	fpcs_st_t state_r;
	fpcs_pkg::fpcs_op_t op_r;
	logic [fpcs_pkg::ADDR_W-1:0] addr_r;
	logic [fpcs_pkg::DATA_W-1:0] data_r;
	logic [7:0] cnt_r;
	logic pend_r;
	logic susp_ok_r;
	logic first_r;
	logic [7:0] last_code_r;
	logic bus_go;
	logic bus_start;
	logic bus_idle;
	logic bus_done;
	logic susp_take;
	logic [fpcs_pkg::DATA_W-1:0] bus_rdata;
	fpcs_pkg::fpcs_cyc_t cyc;
	fpcs_pkg::fpcs_stat_t rd_stat;

	function automatic logic [7:0] cmd_of(input fpcs_pkg::fpcs_op_t op);
		case (op)
			fpcs_pkg::OP_PROGRAM: cmd_of = fpcs_pkg::CMD_WORD_PROG;
			fpcs_pkg::OP_BUF_PROGRAM: cmd_of = fpcs_pkg::CMD_BUF_PROG;
			fpcs_pkg::OP_ERASE: cmd_of = fpcs_pkg::CMD_ERASE;
			fpcs_pkg::OP_LOCK: cmd_of = fpcs_pkg::CMD_LOCK_SETUP;
			fpcs_pkg::OP_SUSPEND: cmd_of = fpcs_pkg::CMD_SUSPEND;
			fpcs_pkg::OP_RESUME: cmd_of = fpcs_pkg::CMD_CONFIRM;
			fpcs_pkg::OP_CLEAR: cmd_of = fpcs_pkg::CMD_CLEAR_STATUS;
			default: cmd_of = fpcs_pkg::CMD_READ_ARRAY;
		endcase
	endfunction

	assign rd_stat = fpcs_pkg::fpcs_stat_t'(bus_rdata[7:0]);
	// A suspend may cut into a running program or erase poll.
	assign susp_take = (state_r == S_POLL) && susp_ok_r && !pend_r && req_valid
		&& (req.op == fpcs_pkg::OP_SUSPEND);
	// Orders other than suspend wait for the idle state.
	assign req_ready = (state_r == S_IDLE) || susp_take;
	assign bus_start = bus_go && bus_idle;
	assign buf_ready = (state_r == S_DATA) && (op_r == fpcs_pkg::OP_BUF_PROGRAM) && bus_done;

	always_comb
	begin
		cyc = '{wr: 1'b1, addr: addr_r, wdata: {8'h00, cmd_of(op_r)}};
		bus_go = !pend_r;
		case (state_r)
			S_CMD: ;
			S_XSR, S_RD: cyc.wr = 1'b0;
			S_POLL:
			begin
				cyc.wr = 1'b0;
				bus_go = !pend_r && !susp_take;
			end
			S_CNT: cyc.wdata = {8'h00, cnt_r};
			S_DATA:
				if (op_r == fpcs_pkg::OP_BUF_PROGRAM)
				begin
					// The first data address sets where the buffer lands.
					cyc.addr = buf_addr;
					cyc.wdata = buf_data;
					bus_go = !pend_r && buf_valid;
				end
				else
					cyc.wdata = data_r;
			S_CONF:
				cyc.wdata = {8'h00, (op_r == fpcs_pkg::OP_LOCK) ?
					fpcs_pkg::CMD_LOCK_CONFIRM : fpcs_pkg::CMD_CONFIRM};
			S_CLR: cyc.wdata = {8'h00, fpcs_pkg::CMD_CLEAR_STATUS};
			default: bus_go = 1'b0;
		endcase
	end

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			pend_r <= 1'b0;
			last_code_r <= 8'h00;
		end
		else
		begin
			if (bus_start)
				pend_r <= 1'b1;
			else if (bus_done)
				pend_r <= 1'b0;
			if (bus_start && cyc.wr)
				last_code_r <= cyc.wdata[7:0];
		end
	end

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			buf_unaligned <= 1'b0;
		else if (state_r == S_IDLE && req_valid)
			buf_unaligned <= 1'b0;
		else if (bus_start && state_r == S_DATA && first_r && op_r == fpcs_pkg::OP_BUF_PROGRAM)
			buf_unaligned <= |buf_addr[fpcs_pkg::ALIGN_BITS-1:0];
	end

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state_r <= S_IDLE;
			op_r <= fpcs_pkg::OP_READ_ARRAY;
			addr_r <= '0;
			data_r <= '0;
			cnt_r <= 8'h00;
			susp_ok_r <= 1'b0;
			first_r <= 1'b0;
			done <= 1'b0;
			refused <= 1'b0;
			status <= '0;
			rdata <= '0;
		end
		else
		begin
			done <= 1'b0;
			refused <= 1'b0;
			case (state_r)
				S_IDLE:
					if (req_valid)
					begin
						op_r <= req.op;
						addr_r <= req.addr;
						data_r <= req.data;
						cnt_r <= req.count;
						susp_ok_r <= 1'b0;
						if (req.op == fpcs_pkg::OP_BUF_PROGRAM && req.count > BUF_MAX_CNT)
						begin
							refused <= 1'b1;
							done <= 1'b1;
						end
						else if (req.op == fpcs_pkg::OP_READ)
							state_r <= S_RD;
						else
							state_r <= S_CMD;
					end
				S_CMD:
					if (bus_done)
						case (op_r)
							fpcs_pkg::OP_PROGRAM: state_r <= S_DATA;
							fpcs_pkg::OP_BUF_PROGRAM: state_r <= S_XSR;
							fpcs_pkg::OP_ERASE, fpcs_pkg::OP_LOCK: state_r <= S_CONF;
							fpcs_pkg::OP_RESUME:
							begin
								susp_ok_r <= 1'b1;
								state_r <= S_POLL;
							end
							fpcs_pkg::OP_SUSPEND: state_r <= S_POLL;
							default:
							begin
								done <= 1'b1;
								state_r <= S_IDLE;
							end
						endcase
				S_XSR:
					if (bus_done)
						state_r <= bus_rdata[fpcs_pkg::BUF_AVAIL_BIT] ? S_CNT : S_CMD;
				S_CNT:
					if (bus_done)
					begin
						first_r <= 1'b1;
						state_r <= S_DATA;
					end
				S_DATA:
					if (bus_done)
					begin
						first_r <= 1'b0;
						if (op_r != fpcs_pkg::OP_BUF_PROGRAM)
						begin
							susp_ok_r <= 1'b1;
							state_r <= S_POLL;
						end
						else if (cnt_r == 8'h00)
							state_r <= S_CONF;
						else
							cnt_r <= cnt_r - 8'h01;
					end
				S_CONF:
					if (bus_done)
					begin
						susp_ok_r <= (op_r != fpcs_pkg::OP_LOCK);
						state_r <= S_POLL;
					end
				S_POLL:
					if (susp_take)
					begin
						op_r <= fpcs_pkg::OP_SUSPEND;
						susp_ok_r <= 1'b0;
						state_r <= S_CMD;
					end
					else if (bus_done)
					begin
						status <= rd_stat;
						if (rd_stat.engine_ready_flag)
						begin
							if (rd_stat.program_error_flag && rd_stat.erase_error_flag)
								state_r <= S_CLR;
							else
							begin
								done <= 1'b1;
								state_r <= S_IDLE;
							end
						end
					end
				S_CLR:
					if (bus_done)
					begin
						done <= 1'b1;
						state_r <= S_IDLE;
					end
				S_RD:
					if (bus_done)
					begin
						rdata <= bus_rdata;
						done <= 1'b1;
						state_r <= S_IDLE;
					end
				default:
					state_r <= S_IDLE;
			endcase
		end
	end

	fpcs_bus_cycle u_cyc (
		.core_clk(core_clk),
		.rstn(rstn),
		.start(bus_start),
		.cyc(cyc),
		.idle(bus_idle),
		.done(bus_done),
		.rdata(bus_rdata),
		.flash_addr(flash_addr),
		.flash_dq_o(flash_dq_o),
		.flash_dq_oe(flash_dq_oe),
		.flash_dq_i(flash_dq_i),
		.flash_ce_n(flash_ce_n),
		.flash_oe_n(flash_oe_n),
		.flash_we_n(flash_we_n)
	);

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);

	chk_buf_setup_code: assert property (bus_start && state_r == S_CMD
		&& op_r == fpcs_pkg::OP_BUF_PROGRAM |-> cyc.wdata[7:0] == fpcs_pkg::CMD_BUF_PROG)
		else $error("buffer program setup code wrong");
	chk_count_legal: assert property (bus_start && state_r == S_CNT
		|-> cyc.wdata[7:0] <= BUF_MAX_CNT && $past(state_r) inside {S_XSR, S_CNT})
		else $error("buffer count out of range");
	chk_buf_commit: assert property (bus_start && state_r == S_CONF
		&& op_r == fpcs_pkg::OP_BUF_PROGRAM |-> cyc.wdata[7:0] == fpcs_pkg::CMD_CONFIRM
		&& cyc.addr == addr_r)
		else $error("buffer commit not D0h to block");
	chk_word_prog_pair: assert property (bus_start && state_r == S_DATA
		&& op_r == fpcs_pkg::OP_PROGRAM |-> last_code_r == fpcs_pkg::CMD_WORD_PROG
		&& cyc.addr == addr_r)
		else $error("program data not after 40h");
	chk_erase_pair: assert property (bus_start && state_r == S_CONF
		&& op_r == fpcs_pkg::OP_ERASE |-> last_code_r == fpcs_pkg::CMD_ERASE
		&& cyc.wdata[7:0] == fpcs_pkg::CMD_CONFIRM)
		else $error("erase confirm not right after setup");
	chk_lock_pair: assert property (bus_start && state_r == S_CONF
		&& op_r == fpcs_pkg::OP_LOCK |-> last_code_r == fpcs_pkg::CMD_LOCK_SETUP
		&& cyc.wdata[7:0] == fpcs_pkg::CMD_LOCK_CONFIRM)
		else $error("lock confirm not right after setup");
	chk_abort_clear: assert property (state_r == S_POLL && bus_done && !susp_take
		&& rd_stat.engine_ready_flag && rd_stat.program_error_flag && rd_stat.erase_error_flag
		|=> bus_start && cyc.wdata[7:0] == fpcs_pkg::CMD_CLEAR_STATUS)
		else $error("sequence error not followed by clear status");
	chk_suspend_issue: assert property (susp_take
		|=> bus_start && cyc.wdata[7:0] == fpcs_pkg::CMD_SUSPEND ##1 state_r == S_CMD)
		else $error("suspend not issued at once");
	chk_one_at_a_time: assert property (req_valid && req_ready
		&& req.op != fpcs_pkg::OP_SUSPEND |-> state_r == S_IDLE && !pend_r)
		else $error("order taken while engine busy");
	chk_done_ready: assert property (done && $past(state_r) == S_POLL
		|-> status.engine_ready_flag)
		else $error("operation ended before ready");
	chk_read_array_code: assert property (bus_start && state_r == S_CMD
		&& op_r == fpcs_pkg::OP_READ_ARRAY |-> cyc.wdata[7:0] == fpcs_pkg::CMD_READ_ARRAY)
		else $error("read array code wrong");

	cov_buf_done: cover property (done && op_r == fpcs_pkg::OP_BUF_PROGRAM);
	cov_xsr_retry: cover property (state_r == S_XSR && bus_done
		&& !bus_rdata[fpcs_pkg::BUF_AVAIL_BIT]);
	cov_suspend: cover property (susp_take);
	cov_abort: cover property (state_r == S_CLR && bus_done);
endmodule

// ### verification/fpcs_flash_model.sv
// Behavioural model of the parallel flash device on the far side of the host sequencer.
`timescale 1ns/1ps
module fpcs_flash_model (
	// Engine timing clock
	input wire logic core_clk,
	// Test controls
	input wire logic vpen_ok,
	input wire logic slow,
	// Device pins
	input wire logic [fpcs_pkg::ADDR_W-1:0] flash_addr,
	input wire logic [fpcs_pkg::DATA_W-1:0] flash_dq_o,
	input wire logic flash_ce_n,
	input wire logic flash_oe_n,
	input wire logic flash_we_n,
	output logic [fpcs_pkg::DATA_W-1:0] flash_dq_i
);
	typedef enum {PH_CMD, PH_CNT, PH_BUF, PH_CONF, PH_PROG, PH_ERASE, PH_LOCK, PH_ABORT} fpcs_ph_t;
	fpcs_ph_t ph = PH_CMD;
	logic [15:0] mem [int];
	bit locked [int];
	logic [5:0] sr = '0;
	logic susp = 0, xsr = 0, avail = 0, miss = 1, smode = 0;
	int busy = 0, saved = 0, left = 0, blk = 0, wa = 0;
	logic [7:0] cmd;
	initial flash_dq_i = '0;

	function automatic int blk_of(input logic [fpcs_pkg::ADDR_W-1:0] a);
		return int'(a >> 16);
	endfunction

	task automatic start(input logic [5:0] err);
		if (!vpen_ok)
			sr = sr | err | 6'h08;
		else
			busy = slow ? 400 : 20;
	endtask

	always @(posedge core_clk)
	begin
		if (busy > 0)
			busy = busy - 1;
		// Status is live, so every new output-enable cycle presents a fresh value.
		if (!flash_ce_n && !flash_oe_n)
			flash_dq_i <= xsr ? {8'h00, avail, 7'h00} : smode ? {8'h00, busy == 0, susp, sr}
				: mem.exists(int'(flash_addr)) ? mem[int'(flash_addr)] : 16'hFFFF;
		else
			flash_dq_i <= ~flash_dq_i;
	end

	// Only the strobe of a selected cycle is a write; the pin's first rise out of reset is not.
	always @(posedge flash_we_n)
	if (flash_ce_n === 1'b0)
	begin
		cmd = flash_dq_o[7:0];
		smode = 1;
		case (ph)
			PH_CNT:
			begin
				left = int'(cmd) + 1;
				xsr = 0;
				wa = -1;
				ph = PH_BUF;
			end
			PH_BUF:
				if (blk_of(flash_addr) != blk)
				begin
					sr = sr | 6'h30;
					ph = PH_ABORT;
				end
				else
				begin
					if (wa < 0)
						wa = int'(flash_addr);
					mem[wa] = flash_dq_o;
					wa++;
					left--;
					if (left == 0)
						ph = PH_CONF;
				end
			PH_CONF:
			begin
				ph = PH_CMD;
				if (cmd == fpcs_pkg::CMD_CONFIRM)
					start(6'h10);
				else
					sr = sr | 6'h30;
			end
			PH_PROG:
			begin
				ph = PH_CMD;
				if (locked.exists(blk_of(flash_addr)))
					sr = sr | 6'h12;
				else
				begin
					start(6'h10);
					if (vpen_ok)
						mem[int'(flash_addr)] = flash_dq_o;
				end
			end
			PH_ERASE:
			begin
				ph = PH_CMD;
				if (cmd == fpcs_pkg::CMD_CONFIRM)
					start(6'h20);
				else
					sr = sr | 6'h30;
			end
			PH_LOCK:
			begin
				ph = PH_CMD;
				if (cmd == fpcs_pkg::CMD_LOCK_CONFIRM)
				begin
					start(6'h10);
					if (vpen_ok)
						locked[blk] = 1;
				end
				else
					sr = sr | 6'h30;
			end
			PH_ABORT:
				if (cmd == fpcs_pkg::CMD_CLEAR_STATUS)
				begin
					sr = '0;
					ph = PH_CMD;
				end
			default:
				if (busy > 0)
				begin
					// Only suspend is heard while busy; a second erase is not queued.
					if (cmd == fpcs_pkg::CMD_SUSPEND)
					begin
						saved = busy;
						busy = 0;
						susp = 1;
					end
				end
				else
					case (cmd)
						fpcs_pkg::CMD_BUF_PROG:
						begin
							xsr = 1;
							avail = !miss;
							miss = 0;
							blk = blk_of(flash_addr);
							if (avail)
								ph = PH_CNT;
						end
						fpcs_pkg::CMD_WORD_PROG: ph = PH_PROG;
						fpcs_pkg::CMD_ERASE: ph = PH_ERASE;
						fpcs_pkg::CMD_LOCK_SETUP:
						begin
							blk = blk_of(flash_addr);
							ph = PH_LOCK;
						end
						fpcs_pkg::CMD_CLEAR_STATUS: sr = '0;
						fpcs_pkg::CMD_READ_ARRAY:
						begin
							smode = 0;
							xsr = 0;
						end
						fpcs_pkg::CMD_CONFIRM:
							if (susp)
							begin
								susp = 0;
								busy = saved;
							end
						default: ;
					endcase
		endcase
	end
endmodule

// ### verification/fpcs_host_ctrl_test.sv
// Self-checking testbench of the flash command sequencer host.
`timescale 1ns/1ps
module fpcs_host_ctrl_test;
	typedef struct {fpcs_pkg::fpcs_op_t op; logic [23:0] a; logic [15:0] d; logic [15:0] e; int chk;} fpcs_row_t;
	logic core_clk = 0, rstn = 0, req_valid = 0, buf_valid = 0, vpen_ok = 1, slow = 0;
	logic req_ready, buf_ready, done, refused, buf_unaligned, dq_oe, ce_n, oe_n, we_n, ref_seen, popped;
	fpcs_pkg::fpcs_req_t req = '0;
	fpcs_pkg::fpcs_stat_t status;
	logic [23:0] buf_addr = '0, fa;
	logic [15:0] buf_data = '0, rdata, dq_o, dq_i;
	logic [23:0] bq_a [4];
	logic [15:0] bq_d [4];
	int bq_i = 0, bq_n = 0, n_mismatch = 0, n_tests = 0;
	fpcs_row_t rows [9] = '{
		'{fpcs_pkg::OP_PROGRAM, 24'h000100, 16'h1234, 16'h0080, 1},
		'{fpcs_pkg::OP_READ_ARRAY, 24'h000000, 16'h0000, 16'h0000, 0},
		'{fpcs_pkg::OP_READ, 24'h000100, 16'h0000, 16'h1234, 2},
		'{fpcs_pkg::OP_ERASE, 24'h010000, 16'h0000, 16'h0080, 1},
		'{fpcs_pkg::OP_LOCK, 24'h020000, 16'h0000, 16'h0080, 1},
		'{fpcs_pkg::OP_PROGRAM, 24'h020010, 16'h5555, 16'h0092, 1},
		'{fpcs_pkg::OP_PROGRAM, 24'h000104, 16'h0777, 16'h0092, 1},
		'{fpcs_pkg::OP_CLEAR, 24'h000000, 16'h0000, 16'h0000, 0},
		'{fpcs_pkg::OP_PROGRAM, 24'h000106, 16'h0888, 16'h0080, 1}};

	always #4 core_clk = ~core_clk;

	fpcs_host_ctrl uut (.core_clk(core_clk), .rstn(rstn), .req_valid(req_valid),
		.req_ready(req_ready), .req(req), .buf_valid(buf_valid), .buf_ready(buf_ready),
		.buf_addr(buf_addr), .buf_data(buf_data), .done(done), .refused(refused),
		.buf_unaligned(buf_unaligned), .status(status), .rdata(rdata), .flash_addr(fa),
		.flash_dq_o(dq_o), .flash_dq_oe(dq_oe), .flash_dq_i(dq_i), .flash_ce_n(ce_n),
		.flash_oe_n(oe_n), .flash_we_n(we_n));
	fpcs_flash_model dev (.core_clk(core_clk), .vpen_ok(vpen_ok), .slow(slow), .flash_addr(fa),
		.flash_dq_o(dq_o), .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n),
		.flash_dq_i(dq_i));

	// Buffer words are offered in order and advanced just after the clock edge that pops each one.
	always @(negedge core_clk)
		if (buf_valid && buf_ready)
			popped = 1;
	always @(posedge core_clk)
	begin
		#1;
		if (popped)
			bq_i++;
		popped = 0;
		buf_valid = bq_i < bq_n;
		buf_addr = bq_a[bq_i & 3];
		buf_data = bq_d[bq_i & 3];
	end

	task check(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask

	// While a strobe is low, the data pins are driven for a write strobe and never for a read.
	always @(negedge core_clk)
		if (rstn && !ce_n && (!we_n || !oe_n))
			check(16'(dq_oe), 16'(!we_n));

	task stop_test;
		$display("Counts: %0d mismatches in %0d comparisons", n_mismatch, n_tests);
		if (n_mismatch == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task wait_for(input bit want_done);
		int k;
		k = 0;
		do
		begin
			@(negedge core_clk);
			k++;
		end
		while ((want_done ? done : req_ready) !== 1'b1 && k < 5000);
		ref_seen = refused;
		if (k >= 5000)
			check(16'h0001, 16'h0000);
	endtask

	task send(input fpcs_pkg::fpcs_op_t op, input logic [23:0] a, input logic [15:0] d,
		input logic [7:0] c);
		@(posedge core_clk);
		#1;
		req = '{op, a, d, c};
		req_valid = 1;
		wait_for(0);
		@(posedge core_clk);
		#1;
		req_valid = 0;
		req.op = fpcs_pkg::OP_READ;
	endtask

	task run(input fpcs_pkg::fpcs_op_t op, input logic [23:0] a, input logic [15:0] d,
		input logic [7:0] c);
		send(op, a, d, c);
		wait_for(1);
	endtask

	task load_buf(input logic [23:0] base, input int n);
		for (int i = 0; i < 4; i++)
		begin
			bq_a[i] = base + 24'(i);
			bq_d[i] = 16'hA000 + 16'(i);
		end
		bq_i = 0;
		bq_n = n;
	endtask

	initial
	begin
		repeat (30000) @(posedge core_clk);
		n_mismatch++;
		stop_test();
	end

	initial
	begin
		repeat (2) @(posedge core_clk);
		check(ce_n, 1'b1);
		check(oe_n, 1'b1);
		check(we_n, 1'b1);
		check(dq_oe, 1'b0);
		check(req_ready, 1'b1);
		check(done, 1'b0);
		#1 rstn = 1;
		foreach (rows[i])
		begin
			run(rows[i].op, rows[i].a, rows[i].d, 8'h00);
			if (rows[i].chk == 1)
				check(status, rows[i].e);
			else if (rows[i].chk == 2)
				check(rdata, rows[i].e);
		end
		for (int c = 0; c < 4; c += 3)
		begin
			load_buf(24'h000200 + 24'(c * 32), c + 1);
			run(fpcs_pkg::OP_BUF_PROGRAM, 24'h000200 + 24'(c * 32), 16'h0000, 8'(c));
			check(status, 16'h0080);
			check(buf_unaligned, 1'b0);
			check(16'(bq_i), 16'(c + 1));
			run(fpcs_pkg::OP_READ_ARRAY, 24'h000000, 16'h0000, 8'h00);
			run(fpcs_pkg::OP_READ, 24'h000200 + 24'(c * 32 + c), 16'h0000, 8'h00);
			check(rdata, 16'hA000 + 16'(c));
		end
		run(fpcs_pkg::OP_BUF_PROGRAM, 24'h000300, 16'h0000, 8'h10);
		check(ref_seen, 1'b1);
		load_buf(24'h01FFFE, 4);
		run(fpcs_pkg::OP_BUF_PROGRAM, 24'h01FFFE, 16'h0000, 8'h03);
		check(status, 16'h00B0);
		check(buf_unaligned, 1'b1);
		run(fpcs_pkg::OP_PROGRAM, 24'h000108, 16'h0999, 8'h00);
		check(status, 16'h0080);
		vpen_ok = 0;
		run(fpcs_pkg::OP_PROGRAM, 24'h000110, 16'h0001, 8'h00);
		check(status, 16'h0098);
		vpen_ok = 1;
		run(fpcs_pkg::OP_CLEAR, 24'h000000, 16'h0000, 8'h00);
		for (int i = 0; i < 2; i++)
		begin
			slow = 1;
			send(i ? fpcs_pkg::OP_ERASE : fpcs_pkg::OP_PROGRAM, 24'h030000, 16'h4321, 8'h00);
			repeat (40) @(posedge core_clk);
			#1;
			check(req_ready, 1'b0);
			send(fpcs_pkg::OP_SUSPEND, 24'h000000, 16'h0000, 8'h00);
			wait_for(0);
			check(status, 16'h00C0);
			slow = 0;
			run(fpcs_pkg::OP_READ_ARRAY, 24'h000000, 16'h0000, 8'h00);
			run(fpcs_pkg::OP_READ, 24'h000100, 16'h0000, 8'h00);
			check(rdata, 16'h1234);
			run(fpcs_pkg::OP_RESUME, 24'h000000, 16'h0000, 8'h00);
			check(status, 16'h0080);
		end
		// A reset in mid-poll drops the pins at once and leaves the written word behind.
		send(fpcs_pkg::OP_PROGRAM, 24'h000120, 16'h0ABC, 8'h00);
		repeat (40) @(posedge core_clk);
		#1 rstn = 0;
		@(negedge core_clk);
		check(ce_n, 1'b1);
		check(oe_n, 1'b1);
		check(dq_oe, 1'b0);
		check(req_ready, 1'b1);
		check(done, 1'b0);
		repeat (30) @(posedge core_clk);
		#1 rstn = 1;
		run(fpcs_pkg::OP_READ_ARRAY, 24'h000000, 16'h0000, 8'h00);
		run(fpcs_pkg::OP_READ, 24'h000120, 16'h0000, 8'h00);
		check(rdata, 16'h0ABC);
		stop_test();
	end
endmodule
